//--- sdtc_pkg.sv
// package: register map, field layout and timing constants for the sdram config block
package sdtc_pkg;
    // register byte addresses on the axi4-lite slave
    localparam logic [7:0] ADDR_BASE_EH   = 8'h00;
    localparam logic [7:0] ADDR_SPEED     = 8'h04;
    localparam logic [7:0] ADDR_COUNTER   = 8'h08;
    localparam logic [7:0] ADDR_CLK_MHZ   = 8'h0C;
    localparam logic [7:0] ADDR_SIZE_EH   = 8'h10;

    // speed attribute field positions, lsb index (bit 0 = msb convention)
    localparam int LAT_BIT   = 28;   // bit 3 msb-first
    localparam int RC_LSB    = 24;   // bits 5..7 msb-first
    localparam int RAS_LSB   = 20;   // bits 10..11 msb-first
    localparam int SWR_BIT   = 17;   // bit 14
    localparam int WR_BIT    = 16;   // bit 15
    localparam int RP_BIT    = 12;   // bit 19
    localparam int RCD_BIT   = 8;    // bit 23

    localparam logic [31:0] SPEED_MASK  = 32'h17331100;
    localparam logic [31:0] SPEED_RESET = 32'h13331100;
    localparam logic [31:0] BASE_RESET  = 32'h00000000;
    localparam logic [7:0]  CLK_MHZ_RESET = 8'h0A;   // 10 MHz system clock

    // timing values in clocks
    localparam logic [3:0] LAT_CL2 = 4'h2;
    localparam logic [3:0] LAT_CL3 = 4'h3;
    localparam logic [3:0] RAS_MIN = 4'h4;
    localparam logic [3:0] WR_SHORT = 4'h1;
    localparam logic [3:0] WR_LONG  = 4'h2;
    localparam logic [3:0] RP_SHORT = 4'h2;
    localparam logic [3:0] RP_LONG  = 4'h3;
    localparam logic [3:0] RCD_SHORT = 4'h2;
    localparam logic [3:0] RCD_LONG  = 4'h3;
    localparam logic [3:0] SWR_HOLD  = 4'h4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timing set handed to the command sequencer
    typedef struct packed {
        logic [3:0] cas_latency;
        logic [3:0] row_cycle;
        logic [3:0] row_active;
        logic [3:0] write_recovery;
        logic [3:0] precharge;
        logic [3:0] act_to_cmd;
        logic [3:0] single_write_hold;
        logic       row_cycle_reserved;
    } sdtc_timing_type;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRESP,
        BUS_RDATA
    } sdtc_bus_state_type;

    typedef struct packed {
        sdtc_bus_state_type bus;
        logic               aw_taken;
        logic               w_taken;
        logic [7:0]         aw_addr;
        logic [31:0]        w_data;
        logic [3:0]         w_strb;
        logic [1:0]         bresp;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
        logic [31:0]        base_eh;
        logic [31:0]        size_eh;
        logic [31:0]        speed;
        logic [7:0]         clk_mhz;
        logic [7:0]         presc;
        logic [31:0]        counter;
        logic               mrs_req;
        logic [3:0]         mrs_latency;
        logic               close_pages;
        logic [3:0]         block_hit;
        sdtc_timing_type    timing;
    } sdtc_state_type;
endpackage : sdtc_pkg

//--- sdtc_config.sv
// module: register slave, base decode and timing attributes of the sdram controller
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Function
// - refresh closes pages, clears page tracker
// - per-block eight-bit base compared to address
// - bit zero is the most significant
// - larger blocks ignore low base bits
// - latency select picks cas two/three
// - latency toggle issues mode register set
// - row cycle code maps to clocks
// - row active code maps to clocks
// - single write delays precharge four clocks
// - write recovery one or two clocks
// - precharge time two or three clocks
// - activate to command two or three
// - counter ticks per microsecond, reset clears
module sdtc_config (
    input  wire logic                   REF_CLK_IN,
    input  wire logic                   RST_IN,
    input  wire logic [7:0]             S_AXI_AWADDR_IN,
    input  wire logic                   S_AXI_AWVALID_IN,
    output logic                        S_AXI_AWREADY_OUT,
    input  wire logic [31:0]            S_AXI_WDATA_IN,
    input  wire logic [3:0]             S_AXI_WSTRB_IN,
    input  wire logic                   S_AXI_WVALID_IN,
    output logic                        S_AXI_WREADY_OUT,
    output logic [1:0]                  S_AXI_BRESP_OUT,
    output logic                        S_AXI_BVALID_OUT,
    input  wire logic                   S_AXI_BREADY_IN,
    input  wire logic [7:0]             S_AXI_ARADDR_IN,
    input  wire logic                   S_AXI_ARVALID_IN,
    output logic                        S_AXI_ARREADY_OUT,
    output logic [31:0]                 S_AXI_RDATA_OUT,
    output logic [1:0]                  S_AXI_RRESP_OUT,
    output logic                        S_AXI_RVALID_OUT,
    input  wire logic                   S_AXI_RREADY_IN,
    input  wire logic [31:0]            CPU_ADDR_IN,
    input  wire logic                   REFRESH_DONE_IN,
    output logic [3:0]                  BLOCK_HIT_OUT,
    output logic                        CLOSE_PAGES_OUT,
    output logic                        MRS_REQ_OUT,
    output logic [3:0]                  MRS_LATENCY_OUT,
    output sdtc_pkg::sdtc_timing_type   TIMING_OUT,
    output logic [31:0]                 COUNTER_OUT
);

    sdtc_pkg::sdtc_state_type state;
    sdtc_pkg::sdtc_state_type next_state;
    logic [31:0]              wr_merged;
    logic [3:0]               hit_comb;

    // per-block decode: lane k holds block E+k base, msb-first lanes
    genvar blk;
    generate
        for (blk = 0; blk < 4; blk++) begin : g_block
            logic [7:0] base_byte;
            logic [7:0] size_mask;
            assign base_byte = state.base_eh[31 - 8*blk -: 8];
            // size mask: set bits are ignored base bits, so base aligns
            assign size_mask = state.size_eh[31 - 8*blk -: 8];
            // compare top eight address bits with the unmasked base bits
            assign hit_comb[blk] =
                ((CPU_ADDR_IN[31:24] ^ base_byte) & ~size_mask) == 8'h00;
        end
    endgenerate

    // byte-strobe merge of write data into the addressed register
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    // decode the speed register into clock counts
    function automatic sdtc_pkg::sdtc_timing_type decode(
        input logic [31:0] spd);
        sdtc_pkg::sdtc_timing_type t;
        logic [2:0] rc;
        logic [1:0] ras;
        rc  = spd[sdtc_pkg::RC_LSB +: 3];
        ras = spd[sdtc_pkg::RAS_LSB +: 2];
        t   = '0;
        t.cas_latency = spd[sdtc_pkg::LAT_BIT] ?
            sdtc_pkg::LAT_CL3 : sdtc_pkg::LAT_CL2;
        // codes 0-3 give 8-11, codes 6-7 give 6-7; 4-5 reserved
        case (rc)
            3'h0, 3'h1, 3'h2, 3'h3: t.row_cycle = 4'h8 + {2'h0, rc[1:0]};
            3'h6, 3'h7:             t.row_cycle = {1'h0, rc};
            default: begin
                t.row_cycle          = 4'hB; // reserved: slowest safe value
                t.row_cycle_reserved = 1'h1;
            end
        endcase
        t.row_active = sdtc_pkg::RAS_MIN + {2'h0, ras};
        t.write_recovery = spd[sdtc_pkg::WR_BIT] ?
            sdtc_pkg::WR_LONG : sdtc_pkg::WR_SHORT;
        t.precharge = spd[sdtc_pkg::RP_BIT] ?
            sdtc_pkg::RP_LONG : sdtc_pkg::RP_SHORT;
        t.act_to_cmd = spd[sdtc_pkg::RCD_BIT] ?
            sdtc_pkg::RCD_LONG : sdtc_pkg::RCD_SHORT;
        // zero hold means the sequencer may precharge at normal recovery
        t.single_write_hold = spd[sdtc_pkg::SWR_BIT] ?
            sdtc_pkg::SWR_HOLD : 4'h0;
        return t;
    endfunction : decode

    // read mux for the register map
    function automatic logic [32:0] read_reg(input sdtc_pkg::sdtc_state_type s,
                                             input logic [7:0] a);
        logic [32:0] r;
        r = {1'h0, 32'h00000000};
        case (a)
            sdtc_pkg::ADDR_BASE_EH: r[31:0] = s.base_eh;
            sdtc_pkg::ADDR_SPEED:   r[31:0] = s.speed;
            sdtc_pkg::ADDR_COUNTER: r[31:0] = s.counter;
            sdtc_pkg::ADDR_CLK_MHZ: r[31:0] = {24'h000000, s.clk_mhz};
            sdtc_pkg::ADDR_SIZE_EH: r[31:0] = s.size_eh;
            default:                r[32]   = 1'h1;
        endcase
        return r;
    endfunction : read_reg

    assign wr_merged = merge(
        (state.aw_addr == sdtc_pkg::ADDR_BASE_EH) ? state.base_eh :
        (state.aw_addr == sdtc_pkg::ADDR_SPEED)   ? state.speed :
        (state.aw_addr == sdtc_pkg::ADDR_COUNTER) ? state.counter :
        (state.aw_addr == sdtc_pkg::ADDR_SIZE_EH) ? state.size_eh :
        {24'h000000, state.clk_mhz},
        state.w_data, state.w_strb);

    // next-state logic: bus slave, counter, attribute side effects
    always_comb begin
        logic [32:0] rd;
        logic        do_write;
        logic        new_lat;
        rd       = read_reg(state, S_AXI_ARADDR_IN);
        do_write = 1'h0;
        new_lat  = 1'h0;
        next_state             = state;
        next_state.mrs_req     = 1'h0;
        next_state.close_pages = REFRESH_DONE_IN;
        next_state.block_hit   = hit_comb;

        // microsecond prescaler, divides by the programmed mhz value
        if (state.presc + 8'h01 >= state.clk_mhz) begin
            next_state.presc   = 8'h00;
            next_state.counter = state.counter + 32'h00000001;
        end else begin
            next_state.presc = state.presc + 8'h01;
        end

        case (state.bus)
            sdtc_pkg::BUS_IDLE: begin
                if (S_AXI_AWVALID_IN && !state.aw_taken) begin
                    next_state.aw_taken = 1'h1;
                    next_state.aw_addr  = S_AXI_AWADDR_IN & 8'hFC;
                end
                if (S_AXI_WVALID_IN && !state.w_taken) begin
                    next_state.w_taken = 1'h1;
                    next_state.w_data  = S_AXI_WDATA_IN;
                    next_state.w_strb  = S_AXI_WSTRB_IN;
                end
                if (state.aw_taken && state.w_taken) begin
                    do_write          = 1'h1;
                    next_state.aw_taken = 1'h0;
                    next_state.w_taken  = 1'h0;
                    next_state.bus    = sdtc_pkg::BUS_WRESP;
                    next_state.bresp  = sdtc_pkg::RESP_OKAY;
                end else if (S_AXI_ARVALID_IN && !state.aw_taken
                             && !state.w_taken) begin
                    // reads wait while a write is half taken
                    next_state.rdata = rd[31:0];
                    next_state.rresp = rd[32] ?
                        sdtc_pkg::RESP_SLVERR : sdtc_pkg::RESP_OKAY;
                    next_state.bus   = sdtc_pkg::BUS_RDATA;
                end
            end
            sdtc_pkg::BUS_WRESP: begin
                if (S_AXI_BREADY_IN) begin
                    next_state.bus = sdtc_pkg::BUS_IDLE;
                end
            end
            sdtc_pkg::BUS_RDATA: begin
                if (S_AXI_RREADY_IN) begin
                    next_state.bus = sdtc_pkg::BUS_IDLE;
                end
            end
            default: next_state.bus = sdtc_pkg::BUS_IDLE;
        endcase

        // register write and its side effects
        if (do_write) begin
            case (state.aw_addr)
                sdtc_pkg::ADDR_BASE_EH: next_state.base_eh = wr_merged;
                sdtc_pkg::ADDR_SIZE_EH: next_state.size_eh = wr_merged;
                sdtc_pkg::ADDR_COUNTER: next_state.counter = wr_merged;
                sdtc_pkg::ADDR_CLK_MHZ: next_state.clk_mhz = wr_merged[7:0];
                sdtc_pkg::ADDR_SPEED: begin
                    next_state.speed = wr_merged & sdtc_pkg::SPEED_MASK;
                    new_lat = wr_merged[sdtc_pkg::LAT_BIT];
                    // only a real toggle reloads the device mode register
                    if (new_lat != state.speed[sdtc_pkg::LAT_BIT]) begin
                        next_state.mrs_req     = 1'h1;
                        next_state.mrs_latency = new_lat ?
                            sdtc_pkg::LAT_CL3 : sdtc_pkg::LAT_CL2;
                    end
                end
                default: next_state.bresp = sdtc_pkg::RESP_SLVERR;
            endcase
        end
        next_state.timing = decode(next_state.speed);
    end

    // state register, synchronous reset
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            state             <= '0;
            state.bus         <= sdtc_pkg::BUS_IDLE;
            state.speed       <= sdtc_pkg::SPEED_RESET;
            state.base_eh     <= sdtc_pkg::BASE_RESET;
            state.clk_mhz     <= sdtc_pkg::CLK_MHZ_RESET;
            state.mrs_latency <= sdtc_pkg::LAT_CL3;
            state.timing      <= decode(sdtc_pkg::SPEED_RESET);
        end else begin
            state <= next_state;
        end
    end

    // handshake outputs are combinational, data from flops
    assign S_AXI_AWREADY_OUT = (state.bus == sdtc_pkg::BUS_IDLE)
                               && !state.aw_taken;
    assign S_AXI_WREADY_OUT  = (state.bus == sdtc_pkg::BUS_IDLE)
                               && !state.w_taken;
    assign S_AXI_ARREADY_OUT = (state.bus == sdtc_pkg::BUS_IDLE)
                               && !state.aw_taken && !state.w_taken;
    assign S_AXI_BVALID_OUT  = state.bus == sdtc_pkg::BUS_WRESP;
    assign S_AXI_BRESP_OUT   = state.bresp;
    assign S_AXI_RVALID_OUT  = state.bus == sdtc_pkg::BUS_RDATA;
    assign S_AXI_RDATA_OUT   = state.rdata;
    assign S_AXI_RRESP_OUT   = state.rresp;
    assign BLOCK_HIT_OUT     = state.block_hit;
    assign CLOSE_PAGES_OUT   = state.close_pages;
    assign MRS_REQ_OUT       = state.mrs_req;
    assign MRS_LATENCY_OUT   = state.mrs_latency;
    assign TIMING_OUT        = state.timing;
    assign COUNTER_OUT       = state.counter;

endmodule : sdtc_config
`default_nettype wire

//--- sdtc_config_chk_sva.sv
// checker: refresh, mode-register-set, timing and counter properties
`timescale 1ns/100ps
`default_nettype none
module sdtc_config_chk (
    input wire logic                      REF_CLK_IN,
    input wire logic                      RST_IN,
    input wire logic                      S_AXI_BVALID_OUT,
    input wire logic                      REFRESH_DONE_IN,
    input wire logic                      CLOSE_PAGES_OUT,
    input wire logic                      MRS_REQ_OUT,
    input wire logic [3:0]                MRS_LATENCY_OUT,
    input wire sdtc_pkg::sdtc_timing_type TIMING_OUT,
    input wire logic [31:0]               COUNTER_OUT
);
    default clocking @(posedge REF_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    // page closing follows each refresh by exactly one cycle, never alone
    page_close_a:
        assert property (REFRESH_DONE_IN |=> CLOSE_PAGES_OUT)
        else $error("no page close after refresh");
    close_cause_a:
        assert property (CLOSE_PAGES_OUT |-> $past(REFRESH_DONE_IN))
        else $error("page close without refresh");
    // a mode load is one cycle long and only comes out of a register write
    mrs_pulse_a:
        assert property (MRS_REQ_OUT |=> !MRS_REQ_OUT)
        else $error("mode load longer than one cycle");
    mrs_cause_a:
        assert property (MRS_REQ_OUT |-> S_AXI_BVALID_OUT
            || $past(S_AXI_BVALID_OUT) || $past(S_AXI_BVALID_OUT, 2))
        else $error("mode load without a write");
    mrs_value_a:
        assert property (MRS_REQ_OUT |->
            ##[0:2] (TIMING_OUT.cas_latency == MRS_LATENCY_OUT))
        else $error("mode load latency differs from cas latency");
    // decoded clock counts stay inside their documented tables
    row_cycle_a:
        assert property (!TIMING_OUT.row_cycle_reserved |->
            TIMING_OUT.row_cycle inside {[4'h6:4'hB]})
        else $error("row cycle count out of table");
    row_active_a:
        assert property (TIMING_OUT.row_active inside {[4'h4:4'h7]})
        else $error("row active count out of table");
    bit_times_a:
        assert property (TIMING_OUT.write_recovery inside {4'h1, 4'h2}
            && TIMING_OUT.precharge inside {4'h2, 4'h3}
            && TIMING_OUT.act_to_cmd inside {4'h2, 4'h3})
        else $error("one-bit timing count out of range");
    swr_hold_a:
        assert property (TIMING_OUT.single_write_hold inside {4'h0, 4'h4})
        else $error("single write hold not zero or four");
    // the tick counter steps by one and then rests for at least eight clocks
    count_step_a:
        assert property ($changed(COUNTER_OUT) |->
            (COUNTER_OUT == $past(COUNTER_OUT) + 32'h1)
            ##1 $stable(COUNTER_OUT) [*8])
        else $error("counter step wrong");
    count_clear_a:
        assert property ($fell(RST_IN) |-> COUNTER_OUT == 32'h0)
        else $error("counter not cleared by reset");
endmodule : sdtc_config_chk

bind sdtc_config sdtc_config_chk u_chk (
    .REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN),
    .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT), .REFRESH_DONE_IN(REFRESH_DONE_IN),
    .CLOSE_PAGES_OUT(CLOSE_PAGES_OUT), .MRS_REQ_OUT(MRS_REQ_OUT),
    .MRS_LATENCY_OUT(MRS_LATENCY_OUT), .TIMING_OUT(TIMING_OUT),
    .COUNTER_OUT(COUNTER_OUT)
);
`default_nettype wire

//--- sdtc_mem_model.sv
// partner model: sdram array mode register, page closes and refresh timing
`timescale 1ns/100ps
`default_nettype none
module sdtc_mem_model (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       refresh_req_in,
    input  wire logic [3:0] refresh_lat_in,
    input  wire logic       mrs_req_in,
    input  wire logic [3:0] mrs_latency_in,
    input  wire logic       close_pages_in,
    output logic            refresh_done_out,
    output logic [3:0]      mode_latency_out,
    output logic [7:0]      mrs_count_out,
    output logic [7:0]      close_count_out
);
    logic [3:0] busy;
    // refresh ends a chosen number of clocks after the request, so both
    // a prompt and a slow array can be shown to the controller
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            busy             <= 4'h0;
            refresh_done_out <= 1'b0;
            mode_latency_out <= 4'h0;  // unprogrammed until first load
            mrs_count_out    <= 8'h00;
            close_count_out  <= 8'h00;
        end else begin
            refresh_done_out <= (busy == 4'h1);
            busy <= refresh_req_in ? refresh_lat_in
                                   : busy - {3'h0, busy != 4'h0};
            if (mrs_req_in) begin
                mode_latency_out <= mrs_latency_in;
                mrs_count_out    <= mrs_count_out + 8'h01;
            end
            if (close_pages_in) begin
                close_count_out <= close_count_out + 8'h01;
            end
        end
    end
endmodule : sdtc_mem_model
`default_nettype wire

//--- sdtc_tb.sv
// testbench: register access, timing decode, block select and refresh
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, ref_req;
    logic        refresh_done, close_pages, mrs_req;
    logic [7:0]  awaddr, araddr, mrs_count, close_count;
    logic [3:0]  wstrb, mrs_lat, hit, mode_lat, ref_lat;
    logic [3:0]  rc_tab [8];
    logic [3:0]  hit_tab [6];
    logic [31:0] adr_tab [6];
    logic [1:0]  bresp, rresp;
    logic [2:0]  k;
    logic [31:0] wdata, rdata, cpu_addr, counter, c0, w;
    int          mismatches, cmp_count;
    sdtc_pkg::sdtc_timing_type t, e, reset_t;

    sdtc_config u_dut (
        .REF_CLK_IN(clk), .RST_IN(rst), .S_AXI_AWADDR_IN(awaddr),
        .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb),
        .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
        .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
        .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
        .CPU_ADDR_IN(cpu_addr), .REFRESH_DONE_IN(refresh_done),
        .BLOCK_HIT_OUT(hit), .CLOSE_PAGES_OUT(close_pages),
        .MRS_REQ_OUT(mrs_req), .MRS_LATENCY_OUT(mrs_lat),
        .TIMING_OUT(t), .COUNTER_OUT(counter)
    );
    sdtc_mem_model u_mem (
        .clk_in(clk), .rst_in(rst), .refresh_req_in(ref_req),
        .refresh_lat_in(ref_lat), .mrs_req_in(mrs_req),
        .mrs_latency_in(mrs_lat), .close_pages_in(close_pages),
        .refresh_done_out(refresh_done), .mode_latency_out(mode_lat),
        .mrs_count_out(mrs_count), .close_count_out(close_count)
    );

    // 10 MHz system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    // one write or read; each channel holds until its own ready
    task automatic bus(input logic w_n, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s = 4'hF,
        input logic [1:0] er = sdtc_pkg::RESP_OKAY);
        if (w_n) begin
            awaddr  <= a;
            wdata   <= d;
            wstrb   <= s;
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
        end else begin
            araddr  <= a;
            arvalid <= 1'b1;
            rready  <= 1'b1;
        end
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
        end while (!(w_n ? bvalid : rvalid));
        bready <= 1'b0;
        rready <= 1'b0;
        check(32'(w_n ? bvalid : rvalid), 32'h1);
        check(32'(w_n ? bresp : rresp), 32'(er));
        if (!w_n) check(rdata, d);
        @(posedge clk);
    endtask : bus

    task automatic wait_ticks(input logic [31:0] n);
        logic [31:0] s;
        s = counter;
        while (counter - s < n) @(posedge clk);
    endtask : wait_ticks

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // hang guard, well beyond the roughly 11500 cycles of the tests
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, ref_req} = 6'h00;
        {awaddr, araddr, wstrb, wdata, cpu_addr} = 84'h0;
        ref_lat = 4'h1;
        rst = 1'b1;
        rc_tab = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hB, 4'hB, 4'h6, 4'h7};
        adr_tab = '{32'h12000000, 32'h37FFFFFF, 32'h38000000,
                    32'h56800000, 32'h9A000004, 32'h13000000};
        hit_tab = '{4'h1, 4'h2, 4'h0, 4'h4, 4'h8, 4'h0};
        reset_t = '{sdtc_pkg::LAT_CL3, 4'hB, 4'h7, sdtc_pkg::WR_LONG,
            sdtc_pkg::RP_LONG, sdtc_pkg::RCD_LONG, sdtc_pkg::SWR_HOLD, 1'b0};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset contents, then an unmapped place refused both ways
        bus(1'b0, sdtc_pkg::ADDR_SPEED, sdtc_pkg::SPEED_RESET);
        bus(1'b0, sdtc_pkg::ADDR_BASE_EH, sdtc_pkg::BASE_RESET);
        check(32'(t), 32'(reset_t));
        bus(1'b0, 8'h14, 32'h0, 4'h0, sdtc_pkg::RESP_SLVERR);
        bus(1'b1, 8'h14, 32'hFFFFFFFF, 4'hF, sdtc_pkg::RESP_SLVERR);
        $display("test reset_values done");
        // every row cycle code; each write flips the latency bit
        wait_ticks(100);
        for (int i = 0; i < 8; i++) begin
            k = i[2:0];
            w = {3'h0, k[0], 1'h0, k, 2'h0, k[1:0], 2'h0, k[1], k[0],
                 3'h0, k[1], 3'h0, k[2], 8'h00};
            bus(1'b1, sdtc_pkg::ADDR_SPEED, w | ~sdtc_pkg::SPEED_MASK);
            bus(1'b0, sdtc_pkg::ADDR_SPEED, w);
            wait_ticks(100);
            e = '{k[0] ? sdtc_pkg::LAT_CL3 : sdtc_pkg::LAT_CL2, rc_tab[k],
                sdtc_pkg::RAS_MIN + {2'h0, k[1:0]},
                k[0] ? sdtc_pkg::WR_LONG : sdtc_pkg::WR_SHORT,
                k[1] ? sdtc_pkg::RP_LONG : sdtc_pkg::RP_SHORT,
                k[2] ? sdtc_pkg::RCD_LONG : sdtc_pkg::RCD_SHORT,
                k[1] ? sdtc_pkg::SWR_HOLD : 4'h0, k[2:1] == 2'h2};
            check(32'(t[28:21]), 32'(e[28:21]));
            check(32'(t[20:13]), 32'(e[20:13]));
            check(32'(t[12:0]), 32'(e[12:0]));
            check(32'(mode_lat), 32'(e.cas_latency));
            check(32'(mrs_count), 32'(i + 1));
        end
        // same latency again must not load the mode register
        bus(1'b1, sdtc_pkg::ADDR_SPEED, w);
        wait_ticks(100);
        check(32'(mrs_count), 32'h8);
        $display("test speed_attributes done");
        // byte lanes, masked low base bits, most significant byte first
        bus(1'b1, sdtc_pkg::ADDR_BASE_EH, 32'h12345678);
        bus(1'b1, sdtc_pkg::ADDR_SIZE_EH, 32'h00030000);
        bus(1'b1, sdtc_pkg::ADDR_BASE_EH, 32'hAAAAAA9A, 4'h1);
        bus(1'b0, sdtc_pkg::ADDR_BASE_EH, 32'h1234569A);
        wait_ticks(100);
        for (int i = 0; i < 6; i++) begin
            cpu_addr <= adr_tab[i];
            @(posedge clk);
            @(negedge clk);
            check(32'(hit), 32'(hit_tab[i]));
        end
        $display("test block_select done");
        // a prompt and a slow refresh each close the pages once
        for (int i = 0; i < 2; i++) begin
            ref_lat <= (i == 0) ? 4'h1 : 4'h6;
            ref_req <= 1'b1;
            @(posedge clk);
            ref_req <= 1'b0;
            repeat (10) @(posedge clk);
            check(32'(close_count), 32'(i + 1));
        end
        $display("test refresh done");
        // ten ticks per 100 clocks at 10 MHz, cleared by a mid-run reset
        @(negedge clk);
        c0 = counter;
        repeat (100) @(negedge clk);
        check(counter - c0, 32'h0000000A);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(negedge clk);
        check(counter, 32'h00000000);
        check(32'(t), 32'(reset_t));
        @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        // an eleven clock prescale span gives ten ticks in 110 clocks
        bus(1'b1, sdtc_pkg::ADDR_CLK_MHZ, 32'h0000000B);
        bus(1'b0, sdtc_pkg::ADDR_CLK_MHZ, 32'h0000000B);
        @(negedge clk);
        c0 = counter;
        repeat (110) @(negedge clk);
        check(counter - c0, 32'h0000000A);
        $display("test counter done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
